// >>> hw/spf_pkg.sv
// Constants and carrier types for the switch management register bank.
// Assumes a single 100 MHz clock domain and a byte-addressed word access port.
package spf_pkg;

    // Clock and SPI edge measurement timing
    localparam int CLK_MHZ = 100;
    localparam int SPI_SPLIT_MHZ = 25;
    localparam int SPI_SPLIT_CYCLES = CLK_MHZ / SPI_SPLIT_MHZ;
    localparam int SPI_CNT_W = 8;

    // Global register byte addresses
    localparam logic [15:0] SPI_EDGE_ADDR = 16'h0100;
    localparam logic [15:0] P6_INGRESS_ADDR = 16'h6301;
    localparam logic [1:0] SPI_EDGE_AUTO_BIT = 2'h1;
    localparam logic [1:0] SPI_EDGE_MAN_BIT = 2'h0;
    localparam logic [7:0] SPI_EDGE_RST = 8'h02;
    localparam logic [2:0] P6_DELAY_BIT = 3'h4;
    localparam logic [7:0] P6_INGRESS_RST = 8'h00;

    // PHY register window: 0xN100..0xN13F, N = port number
    localparam logic [5:0] PHY_BLOCK = 6'h04;
    localparam logic [3:0] PHY_FIRST_PORT = 4'h1;
    localparam logic [4:0] PHY_BASIC_CTRL_IDX = 5'h00;
    localparam logic [4:0] PHY_MMD_SETUP_IDX = 5'h0D;
    localparam logic [4:0] PHY_MMD_DATA_IDX = 5'h0E;
    localparam logic [15:0] PHY_BASIC_CTRL_RST = 16'h1140;
    localparam logic [3:0] CTRL_PWR_DOWN_BIT = 4'hB;
    localparam logic [3:0] CTRL_AN_EN_BIT = 4'hC;
    localparam logic [3:0] CTRL_AN_RESTART_BIT = 4'h9;

    // Indirect MMD access
    localparam logic [1:0] MMD_FN_ADDR = 2'h0;
    localparam logic [4:0] MMD_EEE_DEV = 5'h07;
    localparam logic [15:0] MMD_EEE_ADV_REG = 16'h003C;
    localparam logic [15:0] MMD_EEE_ADV_RST = 16'h0006;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } spf_req_t;

    typedef enum logic [1:0] {
        SPF_MEAS_WAIT,
        SPF_MEAS_COUNT,
        SPF_MEAS_DONE
    } spf_meas_t;

endpackage

// >>> hw/spf_regbank.sv
// Management register bank: per-port PHY registers, MMD window, SPI edge and
// port 6 ingress delay control. Assumes host accesses arrive one per cycle
// at most, with word-aligned addresses and byte enables (be[3] = lowest byte).
//
// What this block does
// - Port 6 ingress delay at port6_ingress_timing_control bit 4
// - EEE advertised by default; host clears it
// - Control bit 11 powers each PHY down
// - 16-bit PHY registers at 0xN100..0xN13F
// - Lower range writes touch only addressed bytes
// - Upper range writes zero the unaddressed half
// - Upper range reads return registers normally
// - Auto bit measures SPI clock, picks edge
// - Edge choice frozen after first measurement
// - EEE active only via autonegotiation agreement
// - MMD reached through setup and data registers
`timescale 1ns/1ps

module spf_regbank
    import spf_pkg::*;
#(
    parameter int N_PORTS = 5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire spf_pkg::spf_req_t req,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    input wire logic spi_sclk,
    output logic spi_out_edge,
    output logic p6_rx_delay_en,
    input wire logic [N_PORTS-1:0] partner_eee_ok,
    output logic [N_PORTS-1:0] phy_pwr_down,
    output logic [N_PORTS-1:0] an_restart,
    output logic [N_PORTS-1:0] eee_active
);
    import spf_pkg::*;

    // Register storage
    logic [15:0] phy_q [N_PORTS][32];
    logic [15:0] phy_d [N_PORTS][32];
    logic [15:0] mmd_addr_q [N_PORTS];
    logic [15:0] mmd_addr_d [N_PORTS];
    logic [15:0] eee_adv_q [N_PORTS];
    logic [15:0] eee_adv_d [N_PORTS];
    logic [7:0] edge_q, edge_d;
    logic [7:0] p6_q, p6_d;
    logic rsp_valid_q, rsp_valid_d;
    logic [31:0] rsp_rdata_q, rsp_rdata_d;
    logic [N_PORTS-1:0] an_restart_q, an_restart_d;
    logic [N_PORTS-1:0] eee_active_q, eee_active_d;

    // SPI edge measurement state
    spf_meas_t meas_q, meas_d;
    logic [SPI_CNT_W-1:0] cnt_q, cnt_d;
    logic sclk_prev_q, sclk_prev_d;
    logic auto_sel_q, auto_sel_d;
    logic out_edge_q, out_edge_d;

    // Address decode
    logic [3:0] port_num;
    logic [2:0] pi;
    logic phy_hit;
    logic upper;
    logic [3:0] pair;

    assign port_num = req.addr[15:12];
    assign pi = 3'(port_num - PHY_FIRST_PORT);
    assign phy_hit = (port_num >= PHY_FIRST_PORT)
                  && (port_num < 4'(PHY_FIRST_PORT + N_PORTS))
                  && (req.addr[11:6] == PHY_BLOCK);
    assign upper = req.addr[5];
    assign pair = req.addr[5:2];

    // Register writes, MMD window and read mux
    always_comb begin
        logic [4:0] idx;
        logic [15:0] half;
        logic [15:0] old;
        logic [15:0] cur;
        logic [15:0] mmd_setup;
        logic [15:0] mmd_rd;
        logic bh;
        logic bl;
        idx = '0;
        half = '0;
        old = '0;
        cur = '0;
        bh = 1'b0;
        bl = 1'b0;
        phy_d = phy_q;
        mmd_addr_d = mmd_addr_q;
        eee_adv_d = eee_adv_q;
        edge_d = edge_q;
        p6_d = p6_q;
        an_restart_d = '0;
        mmd_setup = 16'h0000;
        mmd_rd = 16'h0000;
        rsp_valid_d = req_valid;
        rsp_rdata_d = 32'h0000_0000;

        if (req_valid && req.we && phy_hit) begin
            for (int h = 0; h < 2; h++) begin
                idx = {pair, h[0]};
                half = req.wdata[31-16*h -: 16];
                bh = req.be[3-2*h];
                bl = req.be[2-2*h];
                old = phy_q[pi][idx];
                if (upper) begin
                    // Whole pair is loaded; unaddressed bytes become zero
                    cur = {bh ? half[15:8] : 8'h00, bl ? half[7:0] : 8'h00};
                end else begin
                    cur = {bh ? half[15:8] : old[15:8], bl ? half[7:0] : old[7:0]};
                end
                if ((upper && (|req.be)) || bh || bl) begin
                    phy_d[pi][idx] = cur;
                    if (idx == PHY_BASIC_CTRL_IDX) begin
                        an_restart_d[pi] = cur[CTRL_AN_RESTART_BIT];
                    end
                end
            end
            // Indirect MMD access through the data register
            if ((!upper) && (pair == PHY_MMD_DATA_IDX[4:1])
                    && (req.be[3] || req.be[2])) begin
                mmd_setup = phy_q[pi][PHY_MMD_SETUP_IDX];
                if (mmd_setup[15:14] == MMD_FN_ADDR) begin
                    mmd_addr_d[pi] = phy_d[pi][PHY_MMD_DATA_IDX];
                end else if ((mmd_setup[4:0] == MMD_EEE_DEV)
                        && (mmd_addr_q[pi] == MMD_EEE_ADV_REG)) begin
                    eee_adv_d[pi] = phy_d[pi][PHY_MMD_DATA_IDX];
                end
            end
        end

        if (req_valid && req.we) begin
            if ((req.addr == SPI_EDGE_ADDR) && req.be[3]) begin
                edge_d = req.wdata[31:24];
            end
            if ((req.addr == {P6_INGRESS_ADDR[15:2], 2'b00}) && req.be[2]) begin
                p6_d = req.wdata[23:16];
            end
        end

        // Restart is self-clearing
        for (int p = 0; p < N_PORTS; p++) begin
            phy_d[p][PHY_BASIC_CTRL_IDX][CTRL_AN_RESTART_BIT] = 1'b0;
        end

        if (req_valid && !req.we) begin
            if (phy_hit) begin
                // Reads are unaffected by the paired-write behaviour
                rsp_rdata_d = {phy_q[pi][{pair, 1'b0}], phy_q[pi][{pair, 1'b1}]};
                if ((!upper) && (pair == PHY_MMD_DATA_IDX[4:1])) begin
                    mmd_setup = phy_q[pi][PHY_MMD_SETUP_IDX];
                    if (mmd_setup[15:14] == MMD_FN_ADDR) begin
                        mmd_rd = mmd_addr_q[pi];
                    end else if ((mmd_setup[4:0] == MMD_EEE_DEV)
                            && (mmd_addr_q[pi] == MMD_EEE_ADV_REG)) begin
                        mmd_rd = eee_adv_q[pi];
                    end
                    rsp_rdata_d[31:16] = mmd_rd;
                end
            end else if (req.addr == SPI_EDGE_ADDR) begin
                rsp_rdata_d = {edge_q, 24'h00_0000};
            end else if (req.addr == {P6_INGRESS_ADDR[15:2], 2'b00}) begin
                rsp_rdata_d = {8'h00, p6_q, 16'h0000};
            end
        end

        // EEE only when autonegotiation is on and both sides advertise it
        for (int p = 0; p < N_PORTS; p++) begin
            eee_active_d[p] = phy_q[p][PHY_BASIC_CTRL_IDX][CTRL_AN_EN_BIT]
                            && (|eee_adv_q[p][2:1])
                            && partner_eee_ok[p];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int p = 0; p < N_PORTS; p++) begin
                for (int r = 0; r < 32; r++) begin
                    phy_q[p][r] <= 16'h0000;
                end
                phy_q[p][PHY_BASIC_CTRL_IDX] <= PHY_BASIC_CTRL_RST;
                mmd_addr_q[p] <= 16'h0000;
                eee_adv_q[p] <= MMD_EEE_ADV_RST;
            end
            edge_q <= SPI_EDGE_RST;
            p6_q <= P6_INGRESS_RST;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 32'h0000_0000;
            an_restart_q <= '0;
            eee_active_q <= '0;
        end else begin
            phy_q <= phy_d;
            mmd_addr_q <= mmd_addr_d;
            eee_adv_q <= eee_adv_d;
            edge_q <= edge_d;
            p6_q <= p6_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_rdata_q <= rsp_rdata_d;
            an_restart_q <= an_restart_d;
            eee_active_q <= eee_active_d;
        end
    end

    // SPI clock period measurement, taken once after reset
    always_comb begin
        meas_d = meas_q;
        cnt_d = cnt_q;
        auto_sel_d = auto_sel_q;
        sclk_prev_d = spi_sclk;
        case (meas_q)
            SPF_MEAS_WAIT: begin
                if (spi_sclk && !sclk_prev_q) begin
                    meas_d = SPF_MEAS_COUNT;
                    cnt_d = '0;
                end
            end
            SPF_MEAS_COUNT: begin
                if (spi_sclk && !sclk_prev_q) begin
                    // Period at or under split selects the rising edge
                    auto_sel_d = (cnt_q < SPI_CNT_W'(SPI_SPLIT_CYCLES));
                    meas_d = SPF_MEAS_DONE;
                end else if (cnt_q != '1) begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            SPF_MEAS_DONE: begin
                meas_d = SPF_MEAS_DONE;
            end
            default: begin
                meas_d = SPF_MEAS_WAIT;
            end
        endcase
        out_edge_d = edge_q[SPI_EDGE_AUTO_BIT] ? auto_sel_q : edge_q[SPI_EDGE_MAN_BIT];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meas_q <= SPF_MEAS_WAIT;
            cnt_q <= '0;
            sclk_prev_q <= 1'b0;
            auto_sel_q <= 1'b0;
            out_edge_q <= 1'b0;
        end else begin
            meas_q <= meas_d;
            cnt_q <= cnt_d;
            sclk_prev_q <= sclk_prev_d;
            auto_sel_q <= auto_sel_d;
            out_edge_q <= out_edge_d;
        end
    end

    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_rdata_q;
    assign spi_out_edge = out_edge_q;
    assign p6_rx_delay_en = p6_q[P6_DELAY_BIT];
    assign an_restart = an_restart_q;
    assign eee_active = eee_active_q;

    generate
        for (genvar g = 0; g < N_PORTS; g++) begin : g_pd
            assign phy_pwr_down[g] = phy_q[g][PHY_BASIC_CTRL_IDX][CTRL_PWR_DOWN_BIT];
        end
    endgenerate

endmodule

// >>> sim/spf_regbank_sva.sv
// Port checker for the management register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module spf_regbank_sva
    import spf_pkg::*;
#(
    parameter int N_PORTS = 5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire spf_pkg::spf_req_t req,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_rdata,
    input wire logic p6_rx_delay_en,
    input wire logic [N_PORTS-1:0] partner_eee_ok,
    input wire logic [N_PORTS-1:0] phy_pwr_down,
    input wire logic [N_PORTS-1:0] an_restart,
    input wire logic [N_PORTS-1:0] eee_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic wr_any;
    logic bc1_wr;
    logic p6_wr;
    assign wr_any = req_valid && req.we;
    assign bc1_wr = wr_any && req.addr == 16'h1100 && req.be[3];
    assign p6_wr = wr_any && req.addr == 16'h6300 && req.be[2];
    a_rsp_after_req: assert property (req_valid |=> rsp_valid)
        else $error("request not answered");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid))
        else $error("answer without request");
    a_write_no_data: assert property (wr_any |=> rsp_rdata == 32'h0)
        else $error("write answer carries data");
    a_pwr_from_bit: assert property (bc1_wr |=> phy_pwr_down[0] == $past(req.wdata[27]))
        else $error("power down not from bit 11");
    a_pwr_only_write: assert property ($changed(phy_pwr_down) |-> $past(wr_any))
        else $error("power down changed without write");
    a_restart_from_bit: assert property (bc1_wr |=> an_restart[0] == $past(req.wdata[25]))
        else $error("restart pulse not from bit 9");
    a_p6_from_bit: assert property (p6_wr |=> p6_rx_delay_en == $past(req.wdata[20]))
        else $error("ingress delay not from bit 4");
    a_p6_steady: assert property (!p6_wr |=> $stable(p6_rx_delay_en))
        else $error("ingress delay changed without write");
    a_eee_needs_partner: assert property (!partner_eee_ok[0] |=> !eee_active[0])
        else $error("eee active without partner");
endmodule
bind spf_regbank spf_regbank_sva #(.N_PORTS(N_PORTS)) u_sva (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .p6_rx_delay_en(p6_rx_delay_en), .partner_eee_ok(partner_eee_ok),
    .phy_pwr_down(phy_pwr_down), .an_restart(an_restart), .eee_active(eee_active));

// >>> sim/spf_host.sv
// Host controller model driving the register port.
// Assumes the bench supplies the clock; drives at falling edges.
`timescale 1ns/1ps
module spf_host
    import spf_pkg::*;
(
    input wire logic clk,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_rdata,
    output logic req_valid,
    output spf_pkg::spf_req_t req
);
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // One access; answer taken one cycle after the request edge
    task automatic acc(input logic we, input logic [15:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{we, a, be, d};
        @(negedge clk);
        req_valid = 1'b0;
        q = rsp_valid ? rsp_rdata : 32'hFFFF_FFFF;
    endtask
    task automatic mmd(input logic [15:0] b, input logic [15:0] dv, rg, d);
        logic [31:0] q;
        acc(1'b1, b + 16'h0018, 4'h3, {16'h0, dv}, q);
        acc(1'b1, b + 16'h001C, 4'hC, {rg, 16'h0}, q);
        acc(1'b1, b + 16'h0018, 4'h3, {16'h0, dv | 16'h4000}, q);
        acc(1'b1, b + 16'h001C, 4'hC, {d, 16'h0}, q);
    endtask
    // Whole fixup of one port before the next is started
    task automatic fix_port(input logic [3:0] n);
        logic [15:0] b;
        logic [31:0] q;
        logic [15:0] ps [13];
        b = {n, 12'h100};
        ps = '{16'h6EFF, 16'hE6FF, 16'h6EFF, 16'hE6FF, 16'h00FF, 16'h43FF, 16'hC3FF,
               16'h6FFF, 16'h07FF, 16'h0FFF, 16'hE7FF, 16'hEFFF, 16'hEEEE};
        acc(1'b1, b, 4'hC, 32'h2100_0000, q);
        mmd(b, 16'h001C, 16'h0004, 16'h00D0);
        // Power-saving table: registers 0x13..0x1E, then 0x20
        for (int i = 0; i < 13; i++) begin
            mmd(b, 16'h001C, (i == 12) ? 16'h0020 : 16'(16'h0013 + i), ps[i]);
        end
        mmd(b, 16'h0007, 16'h003C, 16'h0000);
        acc(1'b1, b, 4'hC, 32'h1340_0000, q);
    endtask
    // Upper range: read companion, write whole pair
    task automatic pair_wr(input logic [15:0] a, input logic [15:0] d, input logic hi);
        logic [31:0] q;
        acc(1'b0, a, 4'hF, 32'h0, q);
        acc(1'b1, a, 4'hF, hi ? {d, q[15:0]} : {q[31:16], d}, q);
    endtask
endmodule

// >>> sim/switch_phy_register_access_fixups_tb.sv
// Self-checking bench for the management register bank.
// Assumes the host model and the bound port checker are compiled alongside.
`timescale 1ns/1ps
module switch_phy_register_access_fixups_tb;
    import spf_pkg::*;
    logic clk;
    logic sys_rst;
    logic req_valid;
    spf_req_t req;
    logic rsp_valid;
    logic [31:0] rsp_rdata;
    logic spi_sclk;
    logic spi_out_edge;
    logic p6_rx_delay_en;
    logic [4:0] partner_eee_ok;
    logic [4:0] phy_pwr_down;
    logic [4:0] an_restart;
    logic [4:0] eee_active;
    logic [31:0] q;
    int fails;
    int total_checks;
    int restarts;
    spf_regbank #(.N_PORTS(5)) uut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .spi_sclk(spi_sclk),
        .spi_out_edge(spi_out_edge), .p6_rx_delay_en(p6_rx_delay_en),
        .partner_eee_ok(partner_eee_ok), .phy_pwr_down(phy_pwr_down),
        .an_restart(an_restart), .eee_active(eee_active));
    spf_host host (.clk(clk), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .req_valid(req_valid), .req(req));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (an_restart[0]) restarts <= restarts + 1;
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic rst;
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
    endtask
    // Four serial clock rises, h system cycles per half period
    task automatic sclk(input int h);
        repeat (4) begin
            repeat (h) @(negedge clk);
            spi_sclk = 1'b1;
            repeat (h) @(negedge clk);
            spi_sclk = 1'b0;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end
    initial begin
        sys_rst = 1'b1;
        spi_sclk = 1'b0;
        partner_eee_ok = 5'h1F;
        for (int s = 0; s < 2; s++) begin
            rst();
            sclk(s ? 8 : 1);
            repeat (3) @(negedge clk);
            chk(spi_out_edge, s ? 1'b0 : 1'b1);
            sclk(s ? 1 : 8);
            chk(spi_out_edge, s ? 1'b0 : 1'b1);
        end
        host.acc(1'b0, 16'h0100, 4'h8, 32'h0, q);
        chk(q[31:24], SPI_EDGE_RST);
        for (int e = 0; e < 2; e++) begin
            host.acc(1'b1, 16'h0100, 4'h8, {7'h0, ~e[0], 24'h0}, q);
            @(negedge clk);
            chk(spi_out_edge, 32'(!e[0]));
        end
        host.acc(1'b0, 16'h1100, 4'hF, 32'h0, q);
        chk(q, {PHY_BASIC_CTRL_RST, 16'h0});
        host.acc(1'b0, 16'h7100, 4'hF, 32'h0, q);
        chk(q, 32'h0);
        host.acc(1'b0, 16'h6300, 4'h4, 32'h0, q);
        chk(q[23:16], P6_INGRESS_RST);
        host.acc(1'b1, 16'h6300, 4'h4, 32'h0010_0000, q);
        chk(p6_rx_delay_en, 1'b1);
        chk(eee_active, 5'h1F);
        host.acc(1'b1, 16'h2100, 4'h4, 32'h00AA_5555, q);
        host.acc(1'b0, 16'h2100, 4'hF, 32'h0, q);
        chk(q, 32'h11AA_0000);
        host.pair_wr(16'h4120, 16'h1234, 1'b1);
        host.acc(1'b0, 16'h4120, 4'hF, 32'h0, q);
        chk(q, 32'h1234_0000);
        host.acc(1'b1, 16'h4120, 4'h3, 32'hFFFF_BEEF, q);
        host.acc(1'b0, 16'h4120, 4'hF, 32'h0, q);
        chk(q, 32'h0000_BEEF);
        host.acc(1'b1, 16'h4124, 4'h8, 32'h5A5A_5A5A, q);
        host.acc(1'b0, 16'h4124, 4'hF, 32'h0, q);
        chk(q, 32'h5A00_0000);
        host.acc(1'b1, 16'h3100, 4'hC, 32'h0800_0000, q);
        chk(phy_pwr_down, 5'h04);
        host.acc(1'b1, 16'h3100, 4'hC, 32'h1140_0000, q);
        chk(phy_pwr_down, 5'h00);
        partner_eee_ok = 5'h1E;
        @(negedge clk);
        chk(eee_active, 5'h1E);
        partner_eee_ok = 5'h1F;
        for (int p = 1; p <= 5; p++) host.fix_port(p[3:0]);
        @(negedge clk);
        chk(eee_active, 5'h00);
        chk(restarts, 1);
        host.acc(1'b0, 16'h1100, 4'hC, 32'h0, q);
        chk(q[31:16], 16'h1140);
        wrap_up();
    end
endmodule
